/* verif/pcr_host_model.sv */
// Host model driving the command port with single-byte writes and reads
`timescale 1ns/1ps
`default_nettype none

module pcr_host_model (
  input wire logic ref_clk_i, // Device clock
  output logic cmd_wr_o, // Write strobe
  output logic cmd_rd_o, // Read strobe
  output logic [7:0] cmd_addr_o, // Command code
  output logic [7:0] cmd_wdata_o, // Write byte
  input wire logic [7:0] rd_data_i, // Read byte
  input wire logic rd_valid_i // Read valid pulse
);
  // ==========================================================
  // Idle bus; address and data park on inverted values so a stale byte never looks valid
  initial begin
    cmd_wr_o = 1'b0;
    cmd_rd_o = 1'b0;
    cmd_addr_o = 8'hFF;
    cmd_wdata_o = 8'hFF;
  end

  // One byte write, strobe held for exactly one sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    cmd_wr_o <= 1'b1;
    cmd_addr_o <= a;
    cmd_wdata_o <= d;
    @(posedge ref_clk_i);
    cmd_wr_o <= 1'b0;
    cmd_addr_o <= ~a;
    cmd_wdata_o <= ~d;
  endtask : wr

  // One byte read; answer is taken just after the edge that samples the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge ref_clk_i);
    cmd_rd_o <= 1'b1;
    cmd_addr_o <= a;
    @(posedge ref_clk_i);
    cmd_rd_o <= 1'b0;
    cmd_addr_o <= ~a;
    #1;
    d = rd_data_i;
    v = rd_valid_i;
  endtask : rd
endmodule : pcr_host_model

`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the class report and auto-class control registers
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ==========================================================
  // Stimulus and observation signals
  logic ref_clk_i = 1'b0, srst_i = 1'b1;
  logic cmd_wr, cmd_rd, rd_valid;
  logic [7:0] cmd_addr, cmd_wdata, rd_data, got, wv;
  logic [3:0] turn_on = '0, turn_off = '0, manual = '0, semi = '0, det = '0, cls = '0;
  logic [3:0] finger = '0, ssig = '0, dsig = '0, cdone = '0, adone = '0, md, m;
  logic [3:0][3:0] alloc = '0, prev = '0;
  logic [3:0] flag, start, pcut, adj_en;
  logic vld;
  int err_total = 0, cmp_count = 0, n, pv, hits;

  always #5 ref_clk_i = ~ref_clk_i;

  // ==========================================================
  // Design and host
  pcr_class_report_regs #(.REPORT_CYC(16), .MAC_START_CYC(16), .MAC_CLEAR_CYC(16)) pcr_class_report_regs_i (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .cmd_wr_i(cmd_wr), .cmd_rd_i(cmd_rd), .cmd_addr_i(cmd_addr),
    .cmd_wdata_i(cmd_wdata), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .turn_on_i(turn_on),
    .turn_off_i(turn_off), .alloc_class_i(alloc), .manual_mode_i(manual), .semi_auto_i(semi),
    .detection_enable_i(det), .class_enable_i(cls), .finger_limited_i(finger), .prev_class_i(prev),
    .single_sig_i(ssig), .dual_sig_i(dsig), .class_done_i(cdone), .acm_done_i(adone),
    .class_complete_flag_o(flag), .acm_start_o(start), .pcut_adjust_o(pcut), .autoclass_adjust_enable_o(adj_en));
  pcr_host_model pcr_host_model_i (.ref_clk_i(ref_clk_i), .cmd_wr_o(cmd_wr), .cmd_rd_o(cmd_rd),
    .cmd_addr_o(cmd_addr), .cmd_wdata_o(cmd_wdata), .rd_data_i(rd_data), .rd_valid_i(rd_valid));

  // ==========================================================
  // Expected codes, worked out from class numbers
  function automatic logic [3:0] enc_a(input int c, input logic ds);
    if (c == 0) return 4'h3; // Class 0 loads run as class 3
    if (c <= 4) return 4'(c);
    if (ds && c == 5) return 4'hD;
    return 4'(c + 3);
  endfunction : enc_a

  function automatic logic [3:0] enc_p(input int c);
    if (c == 0) return 4'h6; // Previous field has its own class 0 code
    if (c <= 4) return 4'(c);
    return 4'(c + 3);
  endfunction : enc_p

  // ==========================================================
  // Compare, read and pulse helpers
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    pcr_host_model_i.rd(a, got, vld);
    chk("read valid", {7'h00, vld}, 8'h01);
    chk(what, got, exp);
  endtask : rdchk

  task automatic pon(input logic [3:0] mk);
    @(posedge ref_clk_i);
    turn_on <= mk;
    @(posedge ref_clk_i);
    turn_on <= 4'h0;
  endtask : pon

  task automatic poff(input logic [3:0] mk);
    @(posedge ref_clk_i);
    turn_off <= mk;
    @(posedge ref_clk_i);
    turn_off <= 4'h0;
  endtask : poff

  // Classification done on one channel; event flag checked a cycle later
  task automatic cdn(input logic [3:0] mk);
    @(posedge ref_clk_i);
    cdone <= mk;
    @(posedge ref_clk_i);
    cdone <= 4'h0;
    #1;
    chk("complete flag", {4'h0, flag}, {4'h0, mk});
  endtask : cdn

  // ==========================================================
  // Verdict, reached from the main sequence or the watchdog
  task automatic close_out();
    $display("Checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  // Watchdog sized well above the roughly 150 cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_total++;
    close_out();
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'hCEA1D2CC));
    repeat (12) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    for (n = 0; n < 5; n++) rdchk(8'(8'h4C + n), 8'h00, "reset byte");
    rdchk(8'h55, 8'h00, "unmapped");
    wv = 8'($urandom) & 8'h0F;
    pcr_host_model_i.wr(8'h50, wv);
    pcr_host_model_i.wr(8'h4C, 8'hFF);
    rdchk(8'h50, wv, "control");
    rdchk(8'h4C, 8'h00, "class read only");
    chk("adjust enables", {4'h0, adj_en}, wv);
    // Encoding sweep on ch1; even passes force the finger-limited semi-auto case
    for (n = 0; n <= 5; n++) begin
      pv = $urandom_range(0, 4);
      md = (n % 2 == 0) ? 4'hF : 4'($urandom);
      {finger[0], semi[0], det[0], cls[0]} <= md;
      alloc[0] <= 4'(n);
      prev[0] <= 4'(pv);
      dsig[0] <= (n == 5);
      pon(4'h1);
      rdchk(8'h4C, {enc_a(n, n == 5), (md == 4'hF) ? enc_p(pv) : 4'h0}, "class ch1");
      poff(4'h1);
      rdchk(8'h4C, 8'h00, "cleared ch1");
    end
    // Manual channel gets no assigned class
    manual[0] <= 1'b1;
    finger[0] <= 1'b0;
    alloc[0] <= 4'h2;
    pon(4'h1);
    rdchk(8'h4C, 8'h00, "manual ch1");
    poff(4'h1);
    manual[0] <= 1'b0;
    // Single-signature pair, measuring channel alternates
    ssig <= 4'hC;
    for (n = 5; n <= 8; n++) begin
      m = (n % 2 == 1) ? 4'h4 : 4'h8;
      alloc[2] <= (m == 4'h4) ? 4'(n) : 4'h1;
      alloc[3] <= (m == 4'h8) ? 4'(n) : 4'h1;
      pon(4'hC);
      cdn(m);
      rdchk(8'h4E, {enc_a(n, 1'b0), 4'h0}, "pair ch3");
      rdchk(8'h4F, {enc_a(n, 1'b0), 4'h0}, "pair ch4");
      poff(4'hC);
    end
    // Manual measurement with adjust on ch2
    pon(4'h2);
    pcr_host_model_i.wr(8'h50, 8'h22);
    hits = 0;
    for (n = 0; n < 20 && hits == 0; n++) begin
      @(posedge ref_clk_i);
      #1;
      if (start !== 4'h0) hits = 1;
    end
    chk("measure start", {4'h0, start}, 8'h02);
    @(posedge ref_clk_i);
    adone <= 4'h2;
    @(posedge ref_clk_i);
    adone <= 4'h0;
    #1;
    chk("power cut adjust", {4'h0, pcut}, 8'h02);
    rdchk(8'h50, 8'h02, "request cleared");
    // Request on an unpowered channel is dropped at turn-on
    pcr_host_model_i.wr(8'h50, 8'h12);
    pon(4'h1);
    rdchk(8'h50, 8'h02, "request at turn-on");
    // Results with every adjust enable off must leave the power cut to the host
    pcr_host_model_i.wr(8'h50, 8'h00);
    @(posedge ref_clk_i);
    adone <= 4'hF;
    @(posedge ref_clk_i);
    adone <= 4'h0;
    #1;
    chk("adjust disabled", {4'h0, pcut}, 8'h00);
    close_out();
  end
endmodule : tb_top

`default_nettype wire

/* verilog/pcr_class_report_regs.sv */
// Class report registers and auto-class control for four channels
`timescale 1ns/1ps
`default_nettype none

module pcr_class_report_regs #(
  parameter int REPORT_CYC = pcr_pkg::REPORT_CYC, // Bound on class report delay
  parameter int MAC_START_CYC = pcr_pkg::MAC_START_CYC, // Bound on measurement start
  parameter int MAC_CLEAR_CYC = pcr_pkg::MAC_CLEAR_CYC // Bound on request clear
) (
  input wire logic ref_clk_i, // Device clock
  input wire logic srst_i, // Synchronous reset, high
  input wire logic cmd_wr_i, // Command write strobe
  input wire logic cmd_rd_i, // Command read strobe
  input wire logic [7:0] cmd_addr_i, // Command code
  input wire logic [7:0] cmd_wdata_i, // Write data byte
  output logic [7:0] rd_data_o, // Read data byte
  output logic rd_valid_o, // Read data valid pulse
  input wire logic [3:0] turn_on_i, // Channel turned on, pulse
  input wire logic [3:0] turn_off_i, // Channel turned off, pulse
  input wire logic [3:0][3:0] alloc_class_i, // Class number powered at
  input wire logic [3:0] manual_mode_i, // Channel in manual/diagnostic mode
  input wire logic [3:0] semi_auto_i, // Channel in semi-auto mode
  input wire logic [3:0] detection_enable_i, // Detection enabled
  input wire logic [3:0] class_enable_i, // Classification enabled
  input wire logic [3:0] finger_limited_i, // Only one finger given at turn-on
  input wire logic [3:0][3:0] prev_class_i, // Preceding 3-finger class number
  input wire logic [3:0] single_sig_i, // Port holds single-signature 4-pair load
  input wire logic [3:0] dual_sig_i, // Port holds dual-signature 4-pair load
  input wire logic [3:0] class_done_i, // Classification measured here, pulse
  input wire logic [3:0] acm_done_i, // Auto-class results updated, pulse
  output logic [3:0] class_complete_flag_o, // Class complete event, pulse
  output logic [3:0] acm_start_o, // Start auto-class measurement, pulse
  output logic [3:0] pcut_adjust_o, // Device adjusts power cut now, pulse
  output logic [3:0] autoclass_adjust_enable_o // Adjust enable bits
);

  // ==========================================================
  // Class encoder
  // Turns a class number into the register code; illegal numbers read unknown
  function automatic logic [3:0] enc_class(input logic [3:0] num, input logic dual, input logic prev_fmt);
    logic [3:0] code;
    code = pcr_pkg::CODE_UNKNOWN;
    if (num == pcr_pkg::NUM_CLASS0) begin
      code = prev_fmt ? pcr_pkg::CODE_PREV_CLASS0 : pcr_pkg::CODE_UNKNOWN;
    end else if (num <= pcr_pkg::NUM_CLASS4) begin
      code = num;
    end else if (dual && num == pcr_pkg::NUM_CLASS5) begin
      code = pcr_pkg::CODE_DS_CLASS5;
    end else if (!dual && num <= pcr_pkg::NUM_CLASS8) begin
      code = pcr_pkg::CODE_SS_CLASS5 + (num - pcr_pkg::NUM_CLASS5);
    end
    return code;
  endfunction : enc_class

  // Register file state
  logic [3:0] acls_reg [4]; // Assigned class fields
  logic [3:0] pcls_reg [4]; // Previous class fields
  logic mac_reg [4]; // Manual measurement requests
  logic aac_reg [4]; // Adjust enables
  logic pend_reg [4]; // Measurement started, awaiting results
  logic pwr_reg [4]; // Channel powered
  logic clsc_reg [4]; // Class complete pulse
  logic start_reg [4]; // Start pulse
  logic adj_reg [4]; // Adjust pulse

  // Write to the control byte this cycle
  logic ctrl_wr;
  assign ctrl_wr = cmd_wr_i && (cmd_addr_i == pcr_pkg::CMD_AC_CTRL);

  // ==========================================================
  // Per-channel logic
  for (genvar g = 0; g < 4; g++) begin : g_ch
    localparam int P = g ^ 1; // Partner channel of a 4-pair port
    logic [3:0] on_num; // Class number assigned at turn-on
    logic pair_upd; // Single-signature class result lands here
    logic [3:0] pair_num; // Class number from the measuring channel
    assign on_num = (alloc_class_i[g] == pcr_pkg::NUM_CLASS0) ? pcr_pkg::NUM_CLASS3 : alloc_class_i[g];
    assign pair_upd = single_sig_i[g] && !manual_mode_i[g] && (class_done_i[g] || class_done_i[P]);
    logic [3:0] pair_raw; // Class number as allocated on the measuring channel
    assign pair_raw = class_done_i[g] ? alloc_class_i[g] : alloc_class_i[P];
    // Class 0 loads run as class 3 on the paired path as well
    assign pair_num = (pair_raw == pcr_pkg::NUM_CLASS0) ? pcr_pkg::NUM_CLASS3 : pair_raw;

    // Powered tracking
    always_ff @(posedge ref_clk_i) begin
      if (srst_i || turn_off_i[g]) begin
        pwr_reg[g] <= 1'b0;
      end else if (turn_on_i[g]) begin
        pwr_reg[g] <= 1'b1;
      end
    end

    // Assigned class; off clears it ahead of any update
    always_ff @(posedge ref_clk_i) begin
      if (srst_i || turn_off_i[g]) begin
        acls_reg[g] <= pcr_pkg::CODE_UNKNOWN;
      end else if (pair_upd) begin
        acls_reg[g] <= enc_class(pair_num, 1'b0, 1'b0);
      end else if (turn_on_i[g] && manual_mode_i[g]) begin
        acls_reg[g] <= pcr_pkg::CODE_UNKNOWN;
      end else if (turn_on_i[g] && !single_sig_i[g]) begin
        acls_reg[g] <= enc_class(on_num, dual_sig_i[g], 1'b0);
      end
    end

    // Previous class, only kept under semi-auto with discovery running
    always_ff @(posedge ref_clk_i) begin
      if (srst_i || turn_off_i[g]) begin
        pcls_reg[g] <= pcr_pkg::CODE_UNKNOWN;
      end else if (turn_on_i[g]) begin
        if (finger_limited_i[g] && semi_auto_i[g] && detection_enable_i[g] && class_enable_i[g]) begin
          pcls_reg[g] <= enc_class(prev_class_i[g], dual_sig_i[g], 1'b1);
        end else begin
          pcls_reg[g] <= pcr_pkg::CODE_UNKNOWN;
        end
      end
    end

    // Class complete event only on the measuring channel
    always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
        clsc_reg[g] <= 1'b0;
      end else begin
        clsc_reg[g] <= class_done_i[g];
      end
    end

    // Manual request bit; turn-on discards a stale request
    always_ff @(posedge ref_clk_i) begin
      if (srst_i || turn_on_i[g] || turn_off_i[g]) begin
        mac_reg[g] <= 1'b0;
      end else if (ctrl_wr) begin
        mac_reg[g] <= cmd_wdata_i[pcr_pkg::MAC_LSB + g];
      end else if (acm_done_i[g] && pend_reg[g]) begin
        mac_reg[g] <= 1'b0;
      end
    end

    // Adjust enable bit
    always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
        aac_reg[g] <= 1'b0;
      end else if (ctrl_wr) begin
        aac_reg[g] <= cmd_wdata_i[pcr_pkg::AAC_LSB + g];
      end
    end

    // Measurement launch; one start per request, only while powered
    always_ff @(posedge ref_clk_i) begin
      if (srst_i || turn_on_i[g] || turn_off_i[g]) begin
        start_reg[g] <= 1'b0;
        pend_reg[g] <= 1'b0;
      end else begin
        start_reg[g] <= mac_reg[g] && pwr_reg[g] && !pend_reg[g] && !start_reg[g];
        if (start_reg[g]) begin
          pend_reg[g] <= 1'b1;
        end else if (acm_done_i[g] || !mac_reg[g]) begin
          pend_reg[g] <= 1'b0;
        end
      end
    end

    // Power cut adjust only when enabled; else host owns the threshold
    always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
        adj_reg[g] <= 1'b0;
      end else begin
        adj_reg[g] <= acm_done_i[g] && aac_reg[g] && pwr_reg[g];
      end
    end

    assign class_complete_flag_o[g] = clsc_reg[g];
    assign acm_start_o[g] = start_reg[g];
    assign pcut_adjust_o[g] = adj_reg[g];
    assign autoclass_adjust_enable_o[g] = aac_reg[g];

    // ========================================================
    // Checks
    sequence s_req;
      mac_reg[g] && pwr_reg[g] && !pend_reg[g] && !start_reg[g] && !turn_on_i[g] && !turn_off_i[g];
    endsequence
    sequence s_start;
      start_reg[g] ##1 pend_reg[g];
    endsequence
    property p_mac_start;
      @(posedge ref_clk_i) disable iff (srst_i) s_req |=> s_start;
    endproperty
    a_mac_start: assert property (p_mac_start) else $error("request did not start measurement");
    property p_mac_clear;
      @(posedge ref_clk_i) disable iff (srst_i) acm_done_i[g] && pend_reg[g] && !ctrl_wr |=> !mac_reg[g];
    endproperty
    a_mac_clear: assert property (p_mac_clear) else $error("request bit not cleared");
    property p_ignore;
      @(posedge ref_clk_i) disable iff (srst_i) turn_on_i[g] |=> !mac_reg[g] && !start_reg[g] ##1 !start_reg[g];
    endproperty
    a_ignore: assert property (p_ignore) else $error("stale request not discarded");
    property p_off;
      @(posedge ref_clk_i) disable iff (srst_i) turn_off_i[g] |=> acls_reg[g] == 4'h0 && pcls_reg[g] == 4'h0;
    endproperty
    a_off: assert property (p_off) else $error("class fields not cleared at off");
    property p_class0;
      @(posedge ref_clk_i) disable iff (srst_i) turn_on_i[g] && !turn_off_i[g] && !manual_mode_i[g] &&
        !single_sig_i[g] && alloc_class_i[g] == 4'h0 |=> acls_reg[g] == 4'h3;
    endproperty
    a_class0: assert property (p_class0) else $error("class 0 load not assigned class 3");
    property p_manual;
      @(posedge ref_clk_i) disable iff (srst_i) turn_on_i[g] && manual_mode_i[g] |=> acls_reg[g] == 4'h0;
    endproperty
    a_manual: assert property (p_manual) else $error("manual channel got a class");
    property p_dual;
      @(posedge ref_clk_i) disable iff (srst_i) turn_on_i[g] && dual_sig_i[g] && !single_sig_i[g] &&
        !manual_mode_i[g] && !turn_off_i[g] && alloc_class_i[g] == 4'h5 |=> acls_reg[g] == 4'hD;
    endproperty
    a_dual: assert property (p_dual) else $error("dual signature class wrong");
    property p_pair;
      @(posedge ref_clk_i) disable iff (srst_i) class_done_i[P] && !class_done_i[g] && single_sig_i[g] &&
        single_sig_i[P] && !manual_mode_i[g] && !manual_mode_i[P] && !turn_off_i[g] && !turn_off_i[P]
        |=> acls_reg[g] == acls_reg[P];
    endproperty
    a_pair: assert property (p_pair) else $error("pair channels disagree");
    property p_clsc;
      @(posedge ref_clk_i) disable iff (srst_i) class_complete_flag_o[g] |-> $past(class_done_i[g]);
    endproperty
    a_clsc: assert property (p_clsc) else $error("class complete on wrong channel");
    property p_prev;
      @(posedge ref_clk_i) disable iff (srst_i) turn_on_i[g] && !turn_off_i[g] &&
        !(semi_auto_i[g] && detection_enable_i[g] && class_enable_i[g]) |=> pcls_reg[g] == 4'h0;
    endproperty
    a_prev: assert property (p_prev) else $error("previous class outside semi-auto");
    property p_adj;
      @(posedge ref_clk_i) disable iff (srst_i) pcut_adjust_o[g] |-> $past(aac_reg[g]) && $past(acm_done_i[g]);
    endproperty
    a_adj: assert property (p_adj) else $error("adjust without enable");
    property p_codes;
      @(posedge ref_clk_i) disable iff (srst_i) !(acls_reg[g] inside {4'h5, 4'h6, 4'h7, 4'hC, 4'hE, 4'hF});
    endproperty
    a_codes: assert property (p_codes) else $error("reserved assigned code");
  end

  // ==========================================================
  // Read port
  // Reads are side-effect free; unknown commands read zero
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rd_data_o <= pcr_pkg::RST_BYTE;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= cmd_rd_i;
      if (cmd_rd_i) begin
        if (cmd_addr_i == pcr_pkg::CMD_AC_CTRL) begin
          rd_data_o <= {mac_reg[3], mac_reg[2], mac_reg[1], mac_reg[0],
                        aac_reg[3], aac_reg[2], aac_reg[1], aac_reg[0]};
        end else if (cmd_addr_i[7:2] == pcr_pkg::CMD_CLASS_BASE[7:2]) begin
          rd_data_o <= {acls_reg[cmd_addr_i[1:0]], pcls_reg[cmd_addr_i[1:0]]};
        end else begin
          rd_data_o <= pcr_pkg::READ_UNMAPPED;
        end
      end
    end
  end

  property p_ctrl_rst;
    @(posedge ref_clk_i) srst_i |=> !mac_reg[0] && !aac_reg[3] && !mac_reg[3] && !aac_reg[0];
  endproperty
  a_ctrl_rst: assert property (p_ctrl_rst) else $error("control byte not cleared by reset");

endmodule : pcr_class_report_regs

`default_nettype wire

/* verilog/pcr_pkg.sv */
// Constants shared by the class report and auto-class control register bank
`default_nettype none

package pcr_pkg;

  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_CLASS_BASE = 8'h4C; // Channel 1 class byte, 4 in a row
  localparam logic [7:0] CMD_AC_CTRL = 8'h50; // Auto-class control byte
  localparam logic [7:0] RST_BYTE = 8'h00; // Value of every byte after reset
  localparam logic [7:0] READ_UNMAPPED = 8'h00; // Answer to an unknown command

  // ==========================================================
  // Field positions
  localparam int ASSIGNED_LSB = 4; // Assigned class, bits 7-4
  localparam int PREVIOUS_LSB = 0; // Previous class, bits 3-0
  localparam int MAC_LSB = 4; // Manual request bits 7-4
  localparam int AAC_LSB = 0; // Adjust enable bits 3-0

  // ==========================================================
  // Class codes
  localparam logic [3:0] CODE_UNKNOWN = 4'h0; // Unknown / cleared
  localparam logic [3:0] CODE_PREV_CLASS0 = 4'h6; // Class 0, previous field only
  localparam logic [3:0] CODE_SS_CLASS5 = 4'h8; // Class 5 single signature; 6-8 follow
  localparam logic [3:0] CODE_DS_CLASS5 = 4'hD; // Class 5 dual signature
  localparam logic [3:0] NUM_CLASS0 = 4'h0; // Class number zero
  localparam logic [3:0] NUM_CLASS3 = 4'h3; // Stand-in for class 0 loads
  localparam logic [3:0] NUM_CLASS4 = 4'h4; // Highest 2-pair class
  localparam logic [3:0] NUM_CLASS5 = 4'h5; // Lowest 4-pair class
  localparam logic [3:0] NUM_CLASS8 = 4'h8; // Highest class

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 100_000_000; // Device clock rate
  localparam int T_REPORT_MS = 5; // Longest delay to report class
  localparam int T_MAC_START_MS = 10; // Longest delay to start measurement
  localparam int T_MAC_CLEAR_MS = 1; // Longest delay to clear request
  localparam int REPORT_CYC = T_REPORT_MS * (CLK_HZ / 1000); // Rounded down
  localparam int MAC_START_CYC = T_MAC_START_MS * (CLK_HZ / 1000); // Rounded down
  localparam int MAC_CLEAR_CYC = T_MAC_CLEAR_MS * (CLK_HZ / 1000); // Rounded down

endpackage : pcr_pkg

`default_nettype wire
